/* hw/fpl_pkg.sv */
// constants, types and register map of the front panel lamp controller
package fpl_pkg;

	// ********************************************************************
	// timing
	// ********************************************************************
	localparam int CLK_PERIOD_NS  = 50;
	localparam int BLINK_HALF_MS  = 250;
	localparam int STRETCH_MS     = 50;
	localparam int NS_PER_MS      = 1000000;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int STRETCH_CYC    = STRETCH_MS * (NS_PER_MS / CLK_PERIOD_NS);

	// ********************************************************************
	// register map
	// ********************************************************************
	localparam int         ADDR_W        = 5;
	localparam logic [4:0] OFS_CTRL_LOW  = 5'h00;
	localparam logic [4:0] OFS_CTRL_HIGH = 5'h04;
	localparam logic [4:0] OFS_STATUS    = 5'h08;
	localparam logic [4:0] OFS_MASK      = 5'h0C;
	localparam logic [4:0] OFS_LAMPS     = 5'h10;
	localparam int         SWFAIL_BIT    = 0;
	localparam int         GREEN_EN_BIT  = 0;
	localparam int         LAMPS_W       = 8;
	localparam int         MODE_LSB      = 8;
	localparam int         EVT_W         = 4;
	localparam int         EVT_ENUM      = 0;
	localparam int         EVT_SUPPLY    = 1;
	localparam int         EVT_HANDLE    = 2;
	localparam int         EVT_HWFAIL    = 3;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
	localparam int         ACT_W         = 4;
	localparam int         ACT_HUB       = 0;
	localparam int         ACT_ADDON     = 1;
	localparam int         ACT_NET_ONE   = 2;
	localparam int         ACT_NET_TWO   = 3;

	// ********************************************************************
	// types
	// ********************************************************************
	typedef enum logic [1:0] {
		PWR_S0 = 2'h0,
		PWR_S3 = 2'h1,
		PWR_S4 = 2'h2,
		PWR_S5 = 2'h3
	} fpl_power_type;

	typedef enum logic [2:0] {
		HL_GREEN  = 3'h0,
		HL_HANDLE = 3'h1,
		HL_SWFAIL = 3'h3,
		HL_HWFAIL = 3'h2,
		HL_OFF    = 3'h6
	} fpl_health_type;

	typedef struct packed {
		logic green;
		logic red;
	} fpl_red_green_type;

	typedef struct packed {
		logic green;
		logic yellow;
	} fpl_green_yellow_type;

	typedef struct packed {
		logic link;
		logic act;
	} fpl_net_port_type;

	typedef struct packed {
		fpl_power_type power;
		logic          handle_open;
		logic          hw_fail;
	} fpl_board_state_type;

endpackage

/* hw/fpl_front_panel_leds.sv */
// front panel lamp controller with axi4-lite registers and hub sense lines

module fpl_front_panel_leds #(
	parameter int BLINK_HALF_CYC = fpl_pkg::BLINK_HALF_CYC,
	parameter int STRETCH_CYC    = fpl_pkg::STRETCH_CYC
)(
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [fpl_pkg::ADDR_W-1:0]    awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	input  wire logic [fpl_pkg::ADDR_W-1:0]    araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	input  wire fpl_pkg::fpl_board_state_type  board_state,
	input  wire logic                          user_red_drive_output,
	input  wire logic                          sata_hub_act,
	input  wire logic                          sata_addon_act,
	input  wire fpl_pkg::fpl_net_port_type     net_port_one,
	input  wire fpl_pkg::fpl_net_port_type     net_port_two,
	input  wire logic                          enum_n,
	input  wire logic                          supply_fail_n,
	output fpl_pkg::fpl_red_green_type         health_lamp,
	output fpl_pkg::fpl_red_green_type         user_lamp,
	output fpl_pkg::fpl_green_yellow_type      disk_activity_lamp,
	output fpl_pkg::fpl_green_yellow_type      backplane_net_lamp,
	output logic                               enum_sense_input,
	output logic                               supply_fail_sense_input,
	output logic                               supply_degrade_n,
	output logic                               irq
);

	localparam int BW = $clog2(BLINK_HALF_CYC + 1);
	localparam int SW = $clog2(STRETCH_CYC + 1);

	// ********************************************************************
	// helpers
	// ********************************************************************
	// steady level unless busy, then follows the blink phase
	function automatic logic blink_colour(input logic on, input logic busy, input logic ph);
		blink_colour = busy ? ph : on;
	endfunction

	function automatic logic is_mapped(input logic [fpl_pkg::ADDR_W-1:0] a);
		is_mapped = (a == fpl_pkg::OFS_CTRL_LOW) || (a == fpl_pkg::OFS_CTRL_HIGH) ||
			(a == fpl_pkg::OFS_STATUS) || (a == fpl_pkg::OFS_MASK) ||
			(a == fpl_pkg::OFS_LAMPS);
	endfunction

	logic                          software_failure_bit;
	logic                          user_green_enable_bit;
	logic [fpl_pkg::EVT_W-1:0]     status;
	logic [fpl_pkg::EVT_W-1:0]     mask;
	logic [fpl_pkg::EVT_W-1:0]     events;
	logic [fpl_pkg::EVT_W-1:0]     prev_lvl;
	logic [fpl_pkg::EVT_W-1:0]     now_lvl;
	logic [fpl_pkg::ACT_W-1:0]     act_in;
	logic [fpl_pkg::ACT_W-1:0]     act_busy;
	logic [BW-1:0]                 blink_cnt;
	logic                          blink;
	fpl_pkg::fpl_health_type       health_mode;
	fpl_pkg::fpl_health_type       next_health;
	logic                          in_sleep;
	logic                          aw_held;
	logic                          w_held;
	logic [fpl_pkg::ADDR_W-1:0]    aw_addr_q;
	logic [31:0]                   w_data_q;
	logic                          w_lane0_q;
	logic                          wr_do;

	// ********************************************************************
	// blink divider
	// ********************************************************************
	// free-running divider shared by every blinking element
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			blink_cnt <= '0;
			blink     <= 1'b0;
		end
		else if (blink_cnt == BW'(BLINK_HALF_CYC - 1))
		begin
			blink_cnt <= '0;
			blink     <= ~blink;
		end
		else
			blink_cnt <= blink_cnt + BW'(1);
	end

	// ********************************************************************
	// activity stretchers
	// ********************************************************************
	assign act_in = {net_port_two.act, net_port_one.act, sata_addon_act, sata_hub_act};

	generate
		for (genvar i = 0; i < fpl_pkg::ACT_W; i++)
		begin : g_stretch
			logic [SW-1:0] cnt;
			// reload on each pulse so a short burst stays visible
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					cnt <= '0;
				else if (act_in[i])
					cnt <= SW'(STRETCH_CYC);
				else if (cnt != '0)
					cnt <= cnt - SW'(1);
			end
			assign act_busy[i] = (cnt != '0);
		end
	endgenerate

	// ********************************************************************
	// health mode
	// ********************************************************************
	assign in_sleep = (board_state.power != fpl_pkg::PWR_S0);

	// priority decode of the health indication
	always_comb
	begin
		if (in_sleep)
			next_health = fpl_pkg::HL_OFF;
		else if (board_state.hw_fail)
			next_health = fpl_pkg::HL_HWFAIL;
		else if (software_failure_bit)
			next_health = fpl_pkg::HL_SWFAIL;
		else if (board_state.handle_open)
			next_health = fpl_pkg::HL_HANDLE;
		else
			next_health = fpl_pkg::HL_GREEN;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			health_mode <= fpl_pkg::HL_GREEN;
		else
			health_mode <= next_health;
	end

	// ********************************************************************
	// lamp drivers
	// ********************************************************************
	// health lamp; yellow is both elements lit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			health_lamp <= '0;
		else
			case (health_mode)
				fpl_pkg::HL_OFF:    health_lamp <= '0;
				fpl_pkg::HL_GREEN:  health_lamp <= '{green: 1'b1, red: 1'b0};
				fpl_pkg::HL_HANDLE: health_lamp <= '{green: blink, red: blink};
				fpl_pkg::HL_HWFAIL: health_lamp <= '{green: 1'b0, red: 1'b1};
				fpl_pkg::HL_SWFAIL: health_lamp <= '{green: 1'b0, red: blink};
				default:            health_lamp <= '0;
			endcase
	end

	// user and disk lamps; sleep code overrides both
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			user_lamp          <= '0;
			disk_activity_lamp <= '0;
		end
		else if (in_sleep)
		begin
			user_lamp.red             <= 1'b0;
			user_lamp.green           <= (board_state.power != fpl_pkg::PWR_S3);
			disk_activity_lamp.green  <= (board_state.power != fpl_pkg::PWR_S4);
			disk_activity_lamp.yellow <= 1'b0;
		end
		else
		begin
			user_lamp.red             <= user_red_drive_output;
			user_lamp.green           <= user_green_enable_bit;
			disk_activity_lamp.green  <= blink_colour(1'b0, act_busy[fpl_pkg::ACT_HUB],
				blink);
			disk_activity_lamp.yellow <= blink_colour(1'b0, act_busy[fpl_pkg::ACT_ADDON],
				blink);
		end
	end

	// backplane network lamp, one colour per port
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			backplane_net_lamp <= '0;
		else
		begin
			backplane_net_lamp.green  <= blink_colour(net_port_one.link,
				act_busy[fpl_pkg::ACT_NET_ONE], blink);
			backplane_net_lamp.yellow <= blink_colour(net_port_two.link,
				act_busy[fpl_pkg::ACT_NET_TWO], blink);
		end
	end

	// ********************************************************************
	// hub sense lines and events
	// ********************************************************************
	assign supply_degrade_n = 1'b1;
	assign now_lvl = {board_state.hw_fail, board_state.handle_open, supply_fail_n, enum_n};

	// forward backplane lines and keep last levels for edge detection
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			enum_sense_input        <= 1'b1;
			supply_fail_sense_input <= 1'b1;
			prev_lvl                <= 4'h3;
		end
		else
		begin
			enum_sense_input        <= enum_n;
			supply_fail_sense_input <= supply_fail_n;
			prev_lvl                <= now_lvl;
		end
	end

	// enum any change; supply fail falling; handle and hw fail rising
	assign events[fpl_pkg::EVT_ENUM]   = now_lvl[0] ^ prev_lvl[0];
	assign events[fpl_pkg::EVT_SUPPLY] = prev_lvl[1] & ~now_lvl[1];
	assign events[fpl_pkg::EVT_HANDLE] = now_lvl[2] & ~prev_lvl[2];
	assign events[fpl_pkg::EVT_HWFAIL] = now_lvl[3] & ~prev_lvl[3];
	assign irq = |(status & mask);

	// ********************************************************************
	// axi4-lite slave
	// ********************************************************************
	assign awready = ~aw_held & ~bvalid;
	assign wready  = ~w_held & ~bvalid;
	assign arready = ~rvalid;
	assign wr_do   = aw_held & w_held & ~bvalid;

	// address and data taken in either order, answered once both held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_lane0_q <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= fpl_pkg::RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held   <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held    <= 1'b1;
				w_data_q  <= wdata;
				w_lane0_q <= wstrb[0];
			end
			if (wr_do)
			begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= is_mapped(aw_addr_q) ? fpl_pkg::RESP_OKAY : fpl_pkg::RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	// control and mask registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			software_failure_bit  <= 1'b0;
			user_green_enable_bit <= 1'b0;
			mask                  <= '0;
		end
		else if (wr_do && w_lane0_q)
			case (aw_addr_q)
				fpl_pkg::OFS_CTRL_LOW:  software_failure_bit  <= w_data_q[fpl_pkg::SWFAIL_BIT];
				fpl_pkg::OFS_CTRL_HIGH: user_green_enable_bit <= w_data_q[fpl_pkg::GREEN_EN_BIT];
				fpl_pkg::OFS_MASK:      mask <= w_data_q[fpl_pkg::EVT_W-1:0];
				default:                mask <= mask;
			endcase
	end

	// sticky status, write one to clear, a new event wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			status <= '0;
		else if (wr_do && w_lane0_q && aw_addr_q == fpl_pkg::OFS_STATUS)
			status <= (status & ~w_data_q[fpl_pkg::EVT_W-1:0]) | events;
		else
			status <= status | events;
	end

	// read channel, one cycle to answer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= fpl_pkg::RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rresp  <= is_mapped(araddr) ? fpl_pkg::RESP_OKAY : fpl_pkg::RESP_SLVERR;
			case (araddr)
				fpl_pkg::OFS_CTRL_LOW:  rdata <= 32'(software_failure_bit);
				fpl_pkg::OFS_CTRL_HIGH: rdata <= 32'(user_green_enable_bit);
				fpl_pkg::OFS_STATUS:    rdata <= 32'(status);
				fpl_pkg::OFS_MASK:      rdata <= 32'(mask);
				fpl_pkg::OFS_LAMPS:     rdata <= 32'({health_mode, backplane_net_lamp,
					disk_activity_lamp, user_lamp, health_lamp});
				default:                rdata <= 32'h0000_0000;
			endcase
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end

	// ********************************************************************
	// assertions
	// ********************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence seq_sleep_held;
		in_sleep [*2];
	endsequence

	sequence seq_hw_fail_held;
		(!in_sleep && board_state.hw_fail) [*2];
	endsequence

	AST_SLEEP_HEALTH_OFF: assert property (seq_sleep_held |=> health_lamp == '0)
		else $error("health lamp lit in sleep");
	AST_HWFAIL_RED: assert property (seq_hw_fail_held |=>
		health_lamp.red && !health_lamp.green)
		else $error("hardware failure not steady red");
	AST_SWFAIL_MODE: assert property (!in_sleep && !board_state.hw_fail
		&& software_failure_bit |=> health_mode == fpl_pkg::HL_SWFAIL)
		else $error("software failure not shown");
	AST_USER_RED: assert property (!in_sleep |=>
		user_lamp.red == $past(user_red_drive_output))
		else $error("user red does not follow hub output");
	AST_USER_GREEN: assert property (!in_sleep |=>
		user_lamp.green == $past(user_green_enable_bit))
		else $error("user green does not follow enable");
	AST_SLEEP_S4_CODE: assert property (board_state.power == fpl_pkg::PWR_S4
		|=> user_lamp.green && !disk_activity_lamp.green)
		else $error("wrong S4 code");
	AST_NET_NO_LINK: assert property (!net_port_one.link && !net_port_two.link
		&& !act_busy[fpl_pkg::ACT_NET_ONE] && !act_busy[fpl_pkg::ACT_NET_TWO]
		|=> backplane_net_lamp == '0)
		else $error("network lamp lit without link");
	AST_ACT_STRETCH: assert property (sata_hub_act |=> act_busy[fpl_pkg::ACT_HUB] [*8])
		else $error("activity pulse not stretched");
	AST_ENUM_FORWARD: assert property ($changed(enum_n) |=>
		enum_sense_input == $past(enum_n) && status[fpl_pkg::EVT_ENUM])
		else $error("enum change not forwarded");
	AST_SUPPLY_FORWARD: assert property (##1
		supply_fail_sense_input == $past(supply_fail_n) && supply_degrade_n)
		else $error("supply lines wrong");

endmodule

/* verification/fpl_hub_model.sv */
// hub side model: drives the user red output and watches the sense lines
module fpl_hub_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic red_request,
	input  wire logic enum_sense_input,
	input  wire logic supply_fail_sense_input,
	output logic      user_red_drive_output,
	output logic [7:0] enum_changes,
	output logic      supply_alarm
);
	timeunit 1ns;
	timeprecision 1ns;
	logic enum_prev;

	// gpio output register and change counter, as a hub interrupt would see
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			user_red_drive_output <= 1'b0;
			enum_prev             <= 1'b1;
			enum_changes          <= 8'h00;
			supply_alarm          <= 1'b0;
		end
		else
		begin
			user_red_drive_output <= red_request;
			enum_prev             <= enum_sense_input;
			supply_alarm          <= !supply_fail_sense_input;
			if (enum_sense_input != enum_prev)
				enum_changes <= enum_changes + 8'h01;
		end
	end
endmodule

/* verification/front_panel_led_control_tb.sv */
// self-checking bench of the front panel lamp controller
module front_panel_led_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, red_request, red_drive;
	logic sata_hub_act, sata_addon_act, enum_n, supply_fail_n, enum_sense_input;
	logic supply_fail_sense_input, supply_degrade_n, irq, supply_alarm;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [7:0] lv, lor, land, enum_changes;
	fpl_pkg::fpl_board_state_type board_state;
	fpl_pkg::fpl_net_port_type net_port_one, net_port_two;
	fpl_pkg::fpl_red_green_type health_lamp, user_lamp;
	fpl_pkg::fpl_green_yellow_type disk_activity_lamp, backplane_net_lamp;
	int error_cnt, compares, cyc;

	assign lv = {health_lamp, user_lamp, disk_activity_lamp, backplane_net_lamp};

	fpl_front_panel_leds #(.BLINK_HALF_CYC(4), .STRETCH_CYC(10)) dut (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.board_state(board_state), .user_red_drive_output(red_drive),
		.sata_hub_act(sata_hub_act), .sata_addon_act(sata_addon_act),
		.net_port_one(net_port_one), .net_port_two(net_port_two), .enum_n(enum_n),
		.supply_fail_n(supply_fail_n), .health_lamp(health_lamp), .user_lamp(user_lamp),
		.disk_activity_lamp(disk_activity_lamp), .backplane_net_lamp(backplane_net_lamp),
		.enum_sense_input(enum_sense_input), .supply_fail_sense_input(supply_fail_sense_input),
		.supply_degrade_n(supply_degrade_n), .irq(irq));

	fpl_hub_model hub (.aclk(aclk), .aresetn(aresetn), .red_request(red_request),
		.enum_sense_input(enum_sense_input), .supply_fail_sense_input(supply_fail_sense_input),
		.user_red_drive_output(red_drive), .enum_changes(enum_changes),
		.supply_alarm(supply_alarm));

	// ****************************************************************
	// clock, timeout and helpers
	// ****************************************************************
	always #25 aclk = ~aclk;

	// hang guard
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED time=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// collect or/and of all lamp elements over n cycles
	task automatic watch(input int n);
		lor = 8'h00;
		land = 8'hFF;
		repeat (n)
		begin
			@(negedge aclk);
			lor |= lv;
			land &= lv;
		end
		@(posedge aclk);
	endtask

	// ready levels are stable from the falling edge up to the sampling edge
	task automatic axi_write(input logic [4:0] a, input logic [31:0] d);
		logic aw, w, b;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			@(negedge aclk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = (bvalid === 1'b1);
			rs = bresp;
			@(posedge aclk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) bready <= 1'b0;
		end
		@(posedge aclk);
	endtask

	task automatic axi_read(input logic [4:0] a);
		logic ar, r;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r = 1'b0;
		while (!r)
		begin
			@(negedge aclk);
			ar = arvalid && arready;
			r = (rvalid === 1'b1);
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ar) arvalid <= 1'b0;
			if (r) rready <= 1'b0;
		end
		@(posedge aclk);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset();
		chk(32'(lv), 32'h80);
		chk(32'({supply_degrade_n, supply_fail_sense_input, irq}), 32'h6);
		axi_read(fpl_pkg::OFS_LAMPS);
		chk(rd, 32'h2);
		axi_read(5'h14);
		chk({rd[29:0], rs}, 32'(fpl_pkg::RESP_SLVERR));
		axi_write(5'h14, 32'h1);
		chk(32'(rs), 32'(fpl_pkg::RESP_SLVERR));
	endtask

	task automatic t_sleep();
		logic [7:0] exp [4] = '{8'h80, 8'h08, 8'h20, 8'h28};
		for (int s = 1; s < 4; s++)
		begin
			board_state.power <= fpl_pkg::fpl_power_type'(s);
			step(4);
			chk(32'(lv), 32'(exp[s]));
		end
		sata_hub_act <= 1'b1;
		watch(12);
		chk(32'(land[3]), 32'h1);
		sata_hub_act <= 1'b0;
		board_state.power <= fpl_pkg::PWR_S0;
		// let the hub activity stretch run out before the health checks
		step(12);
	endtask

	task automatic t_health();
		board_state.hw_fail <= 1'b1;
		step(4);
		watch(16);
		chk(32'({lor, land}), 32'h4040);
		axi_write(fpl_pkg::OFS_CTRL_LOW, 32'h1);
		axi_read(fpl_pkg::OFS_LAMPS);
		chk(32'(rd[10:8]), 32'h2);
		board_state.hw_fail <= 1'b0;
		board_state.handle_open <= 1'b1;
		step(4);
		watch(16);
		chk(32'({lor, land}), 32'h4000);
		axi_read(fpl_pkg::OFS_LAMPS);
		chk(32'(rd[10:8]), 32'h3);
		axi_write(fpl_pkg::OFS_CTRL_LOW, 32'h0);
		step(4);
		watch(16);
		chk(32'({lor, land}), 32'hC000);
		board_state.handle_open <= 1'b0;
		step(4);
		watch(16);
		chk(32'({lor, land}), 32'h8080);
	endtask

	task automatic t_user();
		red_request <= 1'b1;
		step(3);
		chk(32'(lv[5:4]), 32'h1);
		axi_write(fpl_pkg::OFS_CTRL_HIGH, 32'h1);
		step(2);
		chk(32'(lv[5:4]), 32'h3);
		red_request <= 1'b0;
		step(3);
		chk(32'(lv[5:4]), 32'h2);
		axi_write(fpl_pkg::OFS_CTRL_HIGH, 32'h0);
		step(2);
		chk(32'(lv[5:4]), 32'h0);
	endtask

	task automatic t_disk();
		sata_hub_act <= 1'b1;
		step(1);
		sata_hub_act <= 1'b0;
		watch(12);
		chk(32'({lor[3:2], land[3:2]}), 32'h8);
		step(12);
		sata_addon_act <= 1'b1;
		step(1);
		sata_addon_act <= 1'b0;
		watch(12);
		chk(32'({lor[3:2], land[3:2]}), 32'h4);
		step(12);
		chk(32'(lv), 32'h80);
	endtask

	task automatic t_net();
		for (int i = 0; i < 4; i++)
		begin
			net_port_one.link <= i[1];
			net_port_two.link <= i[0];
			step(3);
			chk(32'(lv[1:0]), 32'(i));
		end
		net_port_two.act <= 1'b1;
		watch(12);
		chk(32'({lor[1:0], land[1:0]}), 32'hE);
		net_port_two.act <= 1'b0;
	endtask

	task automatic t_events();
		axi_write(fpl_pkg::OFS_STATUS, 32'hF);
		axi_write(fpl_pkg::OFS_MASK, 32'h1);
		chk(32'(rs), 32'(fpl_pkg::RESP_OKAY));
		enum_n <= 1'b0;
		step(4);
		chk(32'({irq, enum_sense_input, enum_changes}), 32'h201);
		supply_fail_n <= 1'b0;
		step(3);
		chk(32'({supply_fail_sense_input, supply_alarm}), 32'h1);
		axi_read(fpl_pkg::OFS_STATUS);
		chk(rd, 32'h3);
		axi_write(fpl_pkg::OFS_MASK, 32'h0);
		chk(32'(irq), 32'h0);
		axi_write(fpl_pkg::OFS_STATUS, 32'h1);
		axi_write(fpl_pkg::OFS_MASK, 32'h2);
		axi_read(fpl_pkg::OFS_STATUS);
		chk({rd[30:0], irq}, 32'h5);
		axi_write(fpl_pkg::OFS_STATUS, 32'h2);
		chk(32'(irq), 32'h0);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		aclk = 1'b0;
		aresetn <= 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
		{awaddr, araddr, wdata, wstrb} <= 46'h0;
		board_state <= '{fpl_pkg::PWR_S0, 1'b0, 1'b0};
		{red_request, sata_hub_act, sata_addon_act} <= 3'h0;
		{net_port_one, net_port_two} <= 4'h0;
		{enum_n, supply_fail_n} <= 2'h3;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		step(3);
		t_reset();
		t_sleep();
		t_health();
		t_user();
		t_disk();
		t_net();
		t_events();
		end_of_test();
	end
endmodule
